// [inc/spimsb_pkg.sv]
// Summary of operation
// - data write loads tx buffer; read returns rx
// - only master role starts, by data write
// - master shifts eight bits msb first, exchanging
// - last bit copies shift register to rx, interrupts
// - master drives no slave select output
// - tx byte moves when shifter idle, else waits
// - pending flag until moved; rewrite replaces byte
// - master emits exactly eight clocks per byte
// - fastest rate one-third active, others half
// - slave tx byte waits for select asserted
// - slave shifts only on external clock edges
// - select released early aborts byte, no interrupt
// - each select assertion reloads tx buffer
// - slave runs in suspend; interrupt wakes chip
// - done flag set with interrupt; software clears
// - role field: off, master, slave, reserved
// - polarity bit sets clock idle level
// - rate field selects four master clock rates
// - role off or reserved releases pins; master drives sck and mosi, slave drives miso only
`default_nettype none
package spimsb_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned RATE0_BPS = 2_000_000;
    localparam int unsigned RATE1_BPS = 1_000_000;
    localparam int unsigned RATE2_BPS = 500_000;
    localparam int unsigned RATE3_BPS = 62_500;
    localparam logic [9:0] PER0 = 10'(CLK_HZ / RATE0_BPS);
    localparam logic [9:0] PER1 = 10'(CLK_HZ / RATE1_BPS);
    localparam logic [9:0] PER2 = 10'(CLK_HZ / RATE2_BPS);
    localparam logic [9:0] PER3 = 10'(CLK_HZ / RATE3_BPS);
    // fastest rate: active level one third of the bit, rounded to nearest
    localparam logic [9:0] ACT0 = 10'((CLK_HZ / RATE0_BPS + 1) / 3);
    localparam logic [9:0] ACT1 = 10'(CLK_HZ / RATE1_BPS / 2);
    localparam logic [9:0] ACT2 = 10'(CLK_HZ / RATE2_BPS / 2);
    localparam logic [9:0] ACT3 = 10'(CLK_HZ / RATE3_BPS / 2);
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ==========================================================
    // register map
    localparam int unsigned ADDR_W = 12;
    localparam logic [9:0] DATA_IDX = 10'h060;
    localparam logic [9:0] CTRL_IDX = 10'h061;
    localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int unsigned FLAG_BIT = 7;
    localparam int unsigned PEND_BIT = 6;
    localparam int unsigned ROLE_HI = 5;
    localparam int unsigned ROLE_LO = 4;
    localparam int unsigned POL_BIT = 3;
    localparam int unsigned PHA_BIT = 2;
    localparam int unsigned RATE_HI = 1;
    localparam int unsigned RATE_LO = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {ROLE_OFF, ROLE_MASTER, ROLE_SLAVE, ROLE_RSVD} spimsb_role_e;
    typedef enum logic [1:0] {M_IDLE, M_QUIET, M_ACTIVE} spimsb_mst_e;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } spimsb_pad_s;

    typedef struct packed {
        spimsb_role_e role;
        logic pol;
        logic pha;
        logic [1:0] rate;
    } spimsb_ctrl_s;

endpackage
`default_nettype wire

// [src/spimsb_sync.sv]
`default_nettype none
module spimsb_sync #(
    parameter logic RST_VAL = 1'h0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // level in and out
    input wire logic d,
    output logic q
);

    // ==========================================================
    // two-flop synchroniser; meta feeds only q
    logic meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule
`default_nettype wire

// [src/spimsb_top.sv]
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module spimsb_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [spimsb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [spimsb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins in
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_n_i,
    // serial pins out
    output spimsb_pkg::spimsb_pad_s pad_o,
    output spimsb_pkg::spimsb_pad_s pad_oe,
    // end-of-byte request
    output logic irq
);

    import spimsb_pkg::*;

    // ==========================================================
    // state
    spimsb_ctrl_s ctrl;
    logic flag;
    logic pending;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] sreg;
    logic [2:0] bitcnt;
    logic busy;
    logic samp;
    logic dout;
    spimsb_mst_e mstate;
    logic [9:0] cnt;
    logic sck_q;
    spimsb_pad_s oe_q;
    logic irq_q;

    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_n_s;
    logic sck_d;
    logic ss_n_d;

    logic wr_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;

    // ==========================================================
    // pin synchronisers
    spimsb_sync #(.RST_VAL(1'h0)) u_sync_sck (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(sck_i),
        .q(sck_s)
    );

    spimsb_sync #(.RST_VAL(1'h0)) u_sync_mosi (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(mosi_i),
        .q(mosi_s)
    );

    spimsb_sync #(.RST_VAL(1'h0)) u_sync_miso (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(miso_i),
        .q(miso_s)
    );

    // select resets high so release of reset is no false assertion
    spimsb_sync #(.RST_VAL(1'h1)) u_sync_ss (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(ss_n_i),
        .q(ss_n_s)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_d <= 1'h0;
            ss_n_d <= 1'h1;
        end else begin
            sck_d <= sck_s;
            ss_n_d <= ss_n_s;
        end
    end

    // ==========================================================
    // bus decode
    wire wr_go = wr_rdy && s_axi_awvalid && s_axi_wvalid;
    wire wr_data_hit = s_axi_awaddr == DATA_ADDR;
    wire wr_ctrl_hit = s_axi_awaddr == CTRL_ADDR;
    wire data_wr = wr_go && wr_data_hit && s_axi_wstrb[0];
    wire ctrl_wr = wr_go && wr_ctrl_hit && s_axi_wstrb[0];
    wire rd_go = ar_rdy && s_axi_arvalid;
    wire rd_data_hit = s_axi_araddr == DATA_ADDR;
    wire rd_ctrl_hit = s_axi_araddr == CTRL_ADDR;
    wire [7:0] ctrl_view = {flag, pending, ctrl.role, ctrl.pol, ctrl.pha, ctrl.rate};
    wire [7:0] rd_byte = rd_data_hit ? rx_buf : (rd_ctrl_hit ? ctrl_view : 8'h00);

    // ==========================================================
    // role and event decode
    wire m_mode = ctrl.role == ROLE_MASTER;
    wire s_mode = ctrl.role == ROLE_SLAVE;
    wire ss_act = s_mode && !ss_n_s;
    wire ss_start = ss_act && ss_n_d;
    wire run_ok = m_mode || ss_act;

    // slave edges judged against the idle level
    wire sck_act = sck_s ^ ctrl.pol;
    wire sck_act_d = sck_d ^ ctrl.pol;
    wire s_lead = ss_act && busy && sck_act && !sck_act_d;
    wire s_trail = ss_act && busy && !sck_act && sck_act_d;
    wire m_lead = m_mode && mstate == M_QUIET && cnt == 10'h000;
    wire m_trail = m_mode && mstate == M_ACTIVE && cnt == 10'h000;
    wire lead_ev = m_lead || s_lead;
    wire trail_ev = m_trail || s_trail;
    wire done_ev = trail_ev && bitcnt == LAST_BIT;

    wire rx_in = m_mode ? miso_s : mosi_s;
    wire shift_in = ctrl.pha ? rx_in : samp;
    wire [7:0] next_sreg = {sreg[6:0], shift_in};

    // shifter takes the buffer only when idle; slave also on each select
    wire load_ev = run_ok && (ss_start || (pending && !busy));

    // ==========================================================
    // master clock timing
    wire [9:0] per_sel = ctrl.rate == 2'h0 ? PER0 :
                         ctrl.rate == 2'h1 ? PER1 :
                         ctrl.rate == 2'h2 ? PER2 : PER3;
    wire [9:0] act_sel = ctrl.rate == 2'h0 ? ACT0 :
                         ctrl.rate == 2'h1 ? ACT1 :
                         ctrl.rate == 2'h2 ? ACT2 : ACT3;
    wire [9:0] quiet_sel = per_sel - act_sel;

    spimsb_mst_e next_mstate;
    logic [9:0] next_cnt;

    always_comb begin
        next_mstate = mstate;
        next_cnt = cnt;
        if (!m_mode) begin
            next_mstate = M_IDLE;
            next_cnt = 10'h000;
        end else begin
            unique case (mstate)
                M_IDLE: begin
                    if (load_ev) begin
                        next_mstate = M_QUIET;
                        next_cnt = quiet_sel - 10'h001;
                    end
                end
                M_QUIET: begin
                    if (cnt == 10'h000) begin
                        next_mstate = M_ACTIVE;
                        next_cnt = act_sel - 10'h001;
                    end else begin
                        next_cnt = cnt - 10'h001;
                    end
                end
                M_ACTIVE: begin
                    if (cnt != 10'h000) begin
                        next_cnt = cnt - 10'h001;
                    end else if (bitcnt == LAST_BIT) begin
                        next_mstate = M_IDLE;
                    end else begin
                        next_mstate = M_QUIET;
                        next_cnt = quiet_sel - 10'h001;
                    end
                end
                default: begin
                    next_mstate = M_IDLE;
                    next_cnt = 10'h000;
                end
            endcase
        end
    end

    wire next_sck = ctrl.pol ^ (next_mstate == M_ACTIVE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mstate <= M_IDLE;
            cnt <= 10'h000;
            sck_q <= 1'h0;
        end else begin
            mstate <= next_mstate;
            cnt <= next_cnt;
            sck_q <= next_sck;
        end
    end

    // ==========================================================
    // shift datapath
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sreg <= DATA_RST;
            bitcnt <= 3'h0;
            busy <= 1'h0;
            samp <= 1'h0;
            dout <= 1'h0;
        end else if (!run_ok) begin
            // select released or role left: byte is dropped
            busy <= 1'h0;
            bitcnt <= 3'h0;
        end else if (load_ev) begin
            sreg <= tx_buf;
            busy <= 1'h1;
            bitcnt <= 3'h0;
            if (!ctrl.pha) begin
                dout <= tx_buf[7];
            end
        end else if (lead_ev) begin
            if (!ctrl.pha) begin
                samp <= rx_in;
            end else begin
                dout <= sreg[7];
            end
        end else if (trail_ev) begin
            sreg <= next_sreg;
            bitcnt <= bitcnt + 3'h1;
            if (!ctrl.pha) begin
                dout <= sreg[6];
            end
            if (done_ev) begin
                busy <= 1'h0;
            end
        end
    end

    // ==========================================================
    // transmit buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buf <= DATA_RST;
            pending <= 1'h0;
        end else if (data_wr) begin
            // a new write always wins, even over a move this cycle
            tx_buf <= s_axi_wdata[7:0];
            pending <= 1'h1;
        end else if (load_ev) begin
            pending <= 1'h0;
        end
    end

    // ==========================================================
    // receive buffer, done flag and request
    // an unread byte is simply overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf <= DATA_RST;
            flag <= 1'h0;
            irq_q <= 1'h0;
        end else begin
            if (done_ev) begin
                rx_buf <= next_sreg;
            end
            if (done_ev) begin
                flag <= 1'h1;
            end else if (ctrl_wr && !s_axi_wdata[FLAG_BIT]) begin
                flag <= 1'h0;
            end
            // no suspend gating: the slave path stays live to wake the chip
            irq_q <= done_ev;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= spimsb_ctrl_s'(CTRL_RST[5:0]);
        end else if (ctrl_wr) begin
            ctrl.role <= spimsb_role_e'(s_axi_wdata[ROLE_HI:ROLE_LO]);
            ctrl.pol <= s_axi_wdata[POL_BIT];
            ctrl.pha <= s_axi_wdata[PHA_BIT];
            ctrl.rate <= s_axi_wdata[RATE_HI:RATE_LO];
        end
    end

    // ==========================================================
    // pin drive: no select output exists in master role
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_q <= '0;
        end else begin
            oe_q.sck <= m_mode;
            oe_q.mosi <= m_mode;
            oe_q.miso <= s_mode;
        end
    end

    assign pad_o.sck = sck_q;
    assign pad_o.mosi = dout;
    assign pad_o.miso = dout;
    assign pad_oe = oe_q;
    assign irq = irq_q;

    // ==========================================================
    // axi4-lite write channel
    // address and data are taken together so neither can run ahead
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_rdy <= 1'h0;
            bvalid <= 1'h0;
            bresp <= RESP_OKAY;
        end else begin
            wr_rdy <= !wr_rdy && !bvalid && s_axi_awvalid && s_axi_wvalid;
            if (wr_go) begin
                bvalid <= 1'h1;
                bresp <= (wr_data_hit || wr_ctrl_hit) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid <= 1'h0;
            end
        end
    end

    assign s_axi_awready = wr_rdy;
    assign s_axi_wready = wr_rdy;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;

    // ==========================================================
    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy <= 1'h0;
            rvalid <= 1'h0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            ar_rdy <= !ar_rdy && !rvalid && s_axi_arvalid;
            if (rd_go) begin
                rvalid <= 1'h1;
                rdata <= {24'h00_0000, rd_byte};
                rresp <= (rd_data_hit || rd_ctrl_hit) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid <= 1'h0;
            end
        end
    end

    assign s_axi_arready = ar_rdy;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

endmodule
`default_nettype wire

// [dv/spimsb_top_asserts.sv]
`default_nettype none
module spimsb_top_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [spimsb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // pins and request
    input wire spimsb_pkg::spimsb_pad_s pad_o,
    input wire spimsb_pkg::spimsb_pad_s pad_oe,
    input wire logic irq
);
    import spimsb_pkg::*;
    // ====
    // shadow of the control register
    logic [7:0] ctrl_q;
    logic [1:0] role_d1;
    logic pol_d1, pol_d2, sck_d1;
    logic [9:0] act_cnt;
    logic [3:0] pulses;
    wire logic wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic mapped = s_axi_awaddr == DATA_ADDR || s_axi_awaddr == CTRL_ADDR;
    wire logic pol = ctrl_q[POL_BIT];
    wire logic is_mst = ctrl_q[5:4] == 2'h1 && role_d1 == 2'h1;
    wire logic sck_act = pad_o.sck != pol;
    // a polarity edit moves the idle level; keep it from passing for a pulse
    wire logic sck_end = is_mst && !sck_act && sck_d1 != pol && pol_d1 == pol && pol_d2 == pol;
    wire logic [9:0] act_exp = ctrl_q[1] ? (ctrl_q[0] ? ACT3 : ACT2) : (ctrl_q[0] ? ACT1 : ACT0);
    wire logic [2:0] oe_exp = role_d1 == 2'h1 ? 3'h6 : (role_d1 == 2'h2 ? 3'h1 : 3'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_hs && s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0]) begin
            ctrl_q <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        role_d1 <= ctrl_q[5:4];
        pol_d1 <= pol;
        pol_d2 <= pol_d1;
        sck_d1 <= pad_o.sck;
        act_cnt <= sck_act ? act_cnt + 10'h1 : 10'h0;
        pulses <= (irq || !aresetn) ? 4'h0 : pulses + 4'(sck_end);
    end

    // ====
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_oe_role; ctrl_q[5:4] == role_d1 |-> pad_oe == oe_exp; endproperty
    a_oe_role: assert property (p_oe_role)
        else $error("pin enables wrong for role");
    property p_off_quiet; role_d1 == 2'h0 && ctrl_q[5:4] == 2'h0 |-> !irq; endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("request while off");
    property p_irq_pulse; irq |=> !irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("request longer than one cycle");
    property p_idle_level; irq && is_mst |-> !sck_act; endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("clock not idle at byte end");
    property p_act_len; sck_end |-> act_cnt == act_exp; endproperty
    a_act_len: assert property (p_act_len)
        else $error("clock active part wrong");
    property p_pulses; irq && is_mst |-> pulses + 4'(sck_end) == 4'h8; endproperty
    a_pulses: assert property (p_pulses)
        else $error("clock pulse count wrong");
    property p_b_okay; wr_hs && mapped |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY; endproperty
    a_b_okay: assert property (p_b_okay)
        else $error("write answer missing");
    property p_slverr; wr_hs && !mapped |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR; endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped write not refused");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped");
    property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_ans: assert property (p_r_ans)
        else $error("read answer missing");
endmodule
`default_nettype wire

// [dv/spimsb_far_slave.sv]
`default_nettype none
module spimsb_far_slave (
    // bench control
    input wire logic arm_n,
    input wire logic pol,
    input wire logic pha,
    input wire logic [7:0] reply,
    // serial link
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // behavioural slave, no select from the master
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    int n = 0;
    initial miso = 1'b0;
    initial got = 8'h00;

    always @(negedge arm_n) begin
        n = 0;
        tx = reply;
        miso = reply[7];
    end

    always @(sck) begin
        if (arm_n && sck != pol) begin
            if (pha) begin
                miso = tx[7];
                tx = tx << 1;
            end else begin
                rx = {rx[6:0], mosi};
            end
        end else if (arm_n) begin
            if (pha) begin
                rx = {rx[6:0], mosi};
            end else begin
                tx = tx << 1;
            end
            n++;
            if (n == 8) begin
                got = rx;
                n = 0;
                tx = reply;
                // line is not owned between bytes in phase 1
                miso = pha ? ~miso : tx[7];
            end else if (!pha) begin
                miso = tx[7];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/spi_master_slave_byte_port_tb_top.sv]
`default_nettype none
module spi_master_slave_byte_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spimsb_pkg::*;
    // ====
    // signals
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sck_i, mosi_i, miso_i, ss_n_i, irq, arm_n;
    spimsb_pad_s pad_o, pad_oe;
    logic [7:0] reply, got, cfg;
    int n_errors = 0;
    int compares = 0;
    int n_irq = 0;

    spimsb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i, .mosi_i, .miso_i, .ss_n_i,
        .pad_o, .pad_oe, .irq);
    spimsb_far_slave far (.arm_n, .pol(cfg[POL_BIT]), .pha(cfg[PHA_BIT]), .reply,
        .sck(pad_o.sck), .mosi(pad_o.mosi), .miso(miso_i), .got);

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (irq === 1'b1) n_irq <= n_irq + 1;

    // ====
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(8'(s_axi_bresp), 8'(er));
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(8'(s_axi_rresp), 8'(er));
        chk(s_axi_rdata[7:0], ed);
    endtask
    // link clock 200 ns, mode 0, still outside frames
    task automatic frame(input logic [7:0] m, input int n, output logic [7:0] s);
        s = 8'h00;
        ss_n_i <= 1'b0;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            mosi_i <= m[7-i];
            repeat (4) @(posedge aclk);
            sck_i <= 1'b1;
            repeat (3) @(posedge aclk);
            s = {s[6:0], pad_o.miso};
            @(posedge aclk);
            sck_i <= 1'b0;
        end
        mosi_i <= ~mosi_i;
        repeat (12) @(posedge aclk);
        ss_n_i <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ====
    // tests
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        logic [7:0] s;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {sck_i, mosi_i, arm_n, ss_n_i} = 4'h3;
        reply = 8'h00;
        cfg = 8'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(DATA_ADDR, DATA_RST, RESP_OKAY);
        rd(CTRL_ADDR, CTRL_RST, RESP_OKAY);
        chk(8'(pad_oe), 8'h00);
        rd(CTRL_ADDR + 12'h4, 8'h00, RESP_SLVERR);
        wr(CTRL_ADDR + 12'h4, 8'hFF, RESP_SLVERR);
        for (int r = 0; r < 4; r++) begin
            cfg = {4'h1, r[0], r[1], 2'(r)};
            reply = 8'hA5 ^ 8'(r);
            arm_n <= 1'b0;
            wr(CTRL_ADDR, cfg, RESP_OKAY);
            @(posedge aclk);
            arm_n <= 1'b1;
            wr(DATA_ADDR, 8'h81 + 8'(r), RESP_OKAY);
            wr(DATA_ADDR, 8'hFF, RESP_OKAY);
            rd(CTRL_ADDR, cfg | 8'h40, RESP_OKAY);
            wr(DATA_ADDR, 8'h5A ^ 8'(r), RESP_OKAY);
            while (n_irq < 2 * r + 1) @(posedge aclk);
            chk(got, 8'h81 + 8'(r));
            rd(CTRL_ADDR, cfg | 8'h80, RESP_OKAY);
            rd(DATA_ADDR, reply, RESP_OKAY);
            wr(CTRL_ADDR, cfg, RESP_OKAY);
            rd(CTRL_ADDR, cfg, RESP_OKAY);
            while (n_irq < 2 * r + 2) @(posedge aclk);
            chk(got, 8'h5A ^ 8'(r));
            chk(8'(pad_o.sck), 8'(r[0]));
        end
        wr(CTRL_ADDR, 8'h00, RESP_OKAY);
        wr(DATA_ADDR, 8'h77, RESP_OKAY);
        repeat (200) @(posedge aclk);
        chk(8'(n_irq), 8'h08);
        rd(CTRL_ADDR, 8'h40, RESP_OKAY);
        chk(8'(pad_oe), 8'h00);
        wr(CTRL_ADDR, 8'h30, RESP_OKAY);
        rd(CTRL_ADDR, 8'h70, RESP_OKAY);
        chk(8'(pad_oe), 8'h00);
        wr(CTRL_ADDR, 8'h20, RESP_OKAY);
        rd(CTRL_ADDR, 8'h60, RESP_OKAY);
        chk(8'(pad_oe), 8'h01);
        frame(8'hC3, 4, s);
        rd(CTRL_ADDR, 8'h20, RESP_OKAY);
        chk(8'(n_irq), 8'h08);
        frame(8'hC3, 8, s);
        chk(s, 8'h77);
        chk(8'(n_irq), 8'h09);
        rd(DATA_ADDR, 8'hC3, RESP_OKAY);
        rd(CTRL_ADDR, 8'hA0, RESP_OKAY);
        report_and_stop();
    end
endmodule

bind spimsb_top spimsb_top_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pad_o,
    .pad_oe, .irq);
`default_nettype wire
